// ---- design/fspc_pkg.sv ----
// Purpose: Shared constants and types for the flow-through SRAM pin control block
// Assumes: 32-bit data in four byte lanes, classic Wishbone register port
// Notes:   Offsets are byte addresses on the Wishbone port
package fspc_pkg;

    // Array geometry
    localparam int DATA_W = 32;
    localparam int LANE_W = 8;
    localparam int LANES  = DATA_W / LANE_W;
    localparam int ADDR_W = 18;
    localparam int BURST_W = 2;

    // Register map
    localparam int         WB_ADR_W    = 4;
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;

    // Control register fields
    localparam int CTRL_SOFT_SLEEP = 0;
    localparam logic CTRL_RESET    = 1'h0;

    // Status register fields
    localparam int STAT_SLEEPING = 0;
    localparam int STAT_ACTIVE   = 1;
    localparam int STAT_WR_PEND  = 2;
    localparam int STAT_LINEAR   = 3;
    localparam int STAT_DRIVE_OK = 4;
    localparam int STAT_W        = 5;

    // Burst counter start value on a load
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

    // Operation held by the device between qualified edges
    typedef enum logic [2:0] {
        FSPC_IDLE  = 3'b001,
        FSPC_READ  = 3'b010,
        FSPC_WRITE = 3'b100
    } fspc_op_t;

    // Write waiting for its data cycle
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_n;
    } fspc_wr_t;

endpackage

// ---- design/fspc_pin_ctrl.sv ----
// Purpose: Pin-level control of a flow-through burst SRAM with common data pins
// Assumes: All pin inputs except output enable are synchronous to clk_i; one clock domain
// Notes:   dq_oe_o is the one output built from gates, since the output
//          enable pin must act without a clock edge
//
// Contract
// - Data pin direction combines output-enable pin with clocked internal state.
// - Output enable acts without a clock; low lets pins drive, high floats.
// - Drivers stay off in write data cycle, after deselect, while deselected.
// - Rising edges count only while clock-qualify input is low.
// - Clock-qualify high stretches the current cycle, never deselects.
// - Sleep input high gives low-activity state and keeps memory contents.
// - Pins acting as inputs are captured into the array on the rising edge.
// - Read drives contents of the address sampled at the read's starting edge.
// - Strap low selects linear burst order, high selects interleaved.
// - Write data is taken at the next qualified edge after the write command.
// - Burst counter steps the two low address bits and wraps after four.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

module fspc_pin_ctrl #(
    parameter int ADDR_W = fspc_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Memory command pins
    input  wire logic [ADDR_W-1:0]           addr_i,
    input  wire logic                        write_en_n_i,
    input  wire logic [fspc_pkg::LANES-1:0]  byte_lane_write_n_i,
    input  wire logic                        advance_or_load_i,
    input  wire logic                        chip_sel_a_n_i,
    input  wire logic                        chip_sel_b_i,
    input  wire logic                        chip_sel_c_n_i,
    input  wire logic                        clk_qualify_n_i,
    input  wire logic                        out_en_n_i,
    input  wire logic                        sleep_req_i,
    input  wire logic                        burst_mode_i,
    // Common data pins
    input  wire logic [fspc_pkg::DATA_W-1:0] dq_i,
    output logic      [fspc_pkg::DATA_W-1:0] dq_o,
    output logic                             dq_oe_o,
    // Sleep indication
    output logic                             sleeping_o,
    // Wishbone register port
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [fspc_pkg::WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o
);

    localparam int LANES = fspc_pkg::LANES;
    localparam int LW    = fspc_pkg::LANE_W;
    localparam int BW    = fspc_pkg::BURST_W;
    // The pending-write carrier keeps the package-wide address width
    localparam int WR_AW = fspc_pkg::ADDR_W;

    fspc_pkg::fspc_op_t          op;
    fspc_pkg::fspc_op_t          next_op;
    fspc_pkg::fspc_wr_t          wr;
    logic [ADDR_W-1:0]           base_addr;
    logic [BW-1:0]               burst_cnt;
    logic [BW-1:0]               next_cnt;
    logic [ADDR_W-1:0]           next_addr;
    logic                        drive_ok;
    logic                        linear;
    logic                        soft_sleep;
    logic                        sleeping;
    logic                        qual;
    logic                        selected;
    logic                        wb_req;
    wire  [fspc_pkg::DATA_W-1:0] rd_word;

    // Edges count only while the qualify input is low
    assign qual     = ~clk_qualify_n_i;
    assign sleeping = sleep_req_i | soft_sleep;
    assign selected = ~chip_sel_a_n_i & chip_sel_b_i & ~chip_sel_c_n_i;
    assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Direction: clocked permission gated by the unclocked enable pin
    assign dq_oe_o = drive_ok & ~out_en_n_i;

    // Strap sampled every edge, so a reset needs no pin value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            linear <= 1'b0;
        end else begin
            linear <= ~burst_mode_i;
        end
    end

    // Decode the command presented at this edge
    always_comb begin
        next_op   = fspc_pkg::FSPC_IDLE;
        next_cnt  = fspc_pkg::BURST_START;
        next_addr = addr_i;
        if (sleeping) begin
            next_op = fspc_pkg::FSPC_IDLE;
        end else if (advance_or_load_i) begin
            // Advance keeps the latched direction; chip selects are ignored
            next_op  = op;
            next_cnt = burst_cnt + fspc_pkg::BURST_STEP;
            if (linear) begin
                next_addr = {base_addr[ADDR_W-1:BW], base_addr[BW-1:0] + next_cnt};
            end else begin
                next_addr = {base_addr[ADDR_W-1:BW], base_addr[BW-1:0] ^ next_cnt};
            end
        end else if (selected) begin
            next_op = write_en_n_i ? fspc_pkg::FSPC_READ : fspc_pkg::FSPC_WRITE;
        end
    end

    // Operation and burst state; held over unqualified edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op        <= fspc_pkg::FSPC_IDLE;
            burst_cnt <= fspc_pkg::BURST_START;
            base_addr <= '0;
        end else if (qual) begin
            op        <= next_op;
            burst_cnt <= next_cnt;
            if (!advance_or_load_i) begin
                base_addr <= addr_i;
            end
        end
    end

    // Pending write waits one qualified edge for its data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr <= '0;
        end else if (qual) begin
            wr.valid  <= (next_op == fspc_pkg::FSPC_WRITE);
            wr.addr   <= WR_AW'(next_addr); // Zero-extended into the carrier
            wr.lane_n <= byte_lane_write_n_i;
        end
    end

    // Array lanes; a write in its data cycle is forwarded to a same-edge read
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : lane_g
            logic [LW-1:0] lane_mem [2**ADDR_W];
            logic          fwd;

            assign fwd = wr.valid && !wr.lane_n[g] && (wr.addr[ADDR_W-1:0] == next_addr);
            assign rd_word[g*LW +: LW] = fwd ? dq_i[g*LW +: LW] : lane_mem[next_addr];

            // Capture from the pins at the data edge; no reset keeps contents
            always_ff @(posedge clk_i) begin
                if (qual && wr.valid && !wr.lane_n[g]) begin
                    lane_mem[wr.addr[ADDR_W-1:0]] <= dq_i[g*LW +: LW];
                end
            end
        end
    endgenerate

    // Read data and drive permission for the cycle after the command edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_o     <= '0;
            drive_ok <= 1'b0;
        end else if (qual) begin
            drive_ok <= (next_op == fspc_pkg::FSPC_READ);
            if (next_op == fspc_pkg::FSPC_READ) begin
                dq_o <= rd_word;
            end
        end
    end

    // Sleep flag for the system
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleeping_o <= 1'b0;
        end else begin
            sleeping_o <= sleeping;
        end
    end

    // Control register: software sleep request
    // Taken at the acknowledged edge, where the master still holds the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_sleep <= fspc_pkg::CTRL_RESET;
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == fspc_pkg::REG_CTRL) begin
            soft_sleep <= wb_dat_i[fspc_pkg::CTRL_SOFT_SLEEP];
        end
    end

    // Wishbone answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= '0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    fspc_pkg::REG_CTRL: begin
                        wb_dat_o[fspc_pkg::CTRL_SOFT_SLEEP] <= soft_sleep;
                    end
                    fspc_pkg::REG_STATUS: begin
                        wb_dat_o[fspc_pkg::STAT_SLEEPING] <= sleeping;
                        wb_dat_o[fspc_pkg::STAT_ACTIVE]   <= (op != fspc_pkg::FSPC_IDLE);
                        wb_dat_o[fspc_pkg::STAT_WR_PEND]  <= wr.valid;
                        wb_dat_o[fspc_pkg::STAT_LINEAR]   <= linear;
                        wb_dat_o[fspc_pkg::STAT_DRIVE_OK] <= drive_ok;
                    end
                    default: begin
                        wb_dat_o <= '0;
                    end
                endcase
            end
        end
    end

    // Checks kept beside the logic they watch
    sequence s_read_cmd;
        qual && next_op == fspc_pkg::FSPC_READ;
    endsequence

    sequence s_adv_step;
        qual && advance_or_load_i && !sleeping && op != fspc_pkg::FSPC_IDLE;
    endsequence

    sequence s_load_cmd;
        qual && !advance_or_load_i && !sleeping;
    endsequence

    a_oe_pin_off: assert property (@(posedge clk_i) disable iff (rst_i)
        out_en_n_i |-> !dq_oe_o)
        else $error("data pins driven while output enable is high");

    a_write_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        wr.valid |-> !dq_oe_o)
        else $error("data pins driven in write data cycle");

    a_desel_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (qual && next_op == fspc_pkg::FSPC_IDLE) |=> !dq_oe_o)
        else $error("data pins driven after deselect");

    a_read_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_cmd ##1 !out_en_n_i |-> dq_oe_o)
        else $error("read cycle did not drive with output enable low");

    a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_cmd |=> dq_o == $past(rd_word))
        else $error("read data not from the sampled address");

    a_suspend_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !qual |=> $stable(op) && $stable(dq_o) && $stable(wr) && $stable(drive_ok))
        else $error("state moved on an unqualified edge");

    a_sleep_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (qual && sleeping) [*2] |-> op == fspc_pkg::FSPC_IDLE && !dq_oe_o)
        else $error("device active during sleep");

    a_write_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        (qual && wr.valid && !wr.lane_n[0])
        |=> lane_g[0].lane_mem[$past(wr.addr[ADDR_W-1:0])] == $past(dq_i[LW-1:0]))
        else $error("write data not captured at the data edge");

    a_load_count: assert property (@(posedge clk_i) disable iff (rst_i)
        s_load_cmd |=> burst_cnt == fspc_pkg::BURST_START)
        else $error("burst counter not restarted by a load");

    a_adv_keeps_op: assert property (@(posedge clk_i) disable iff (rst_i)
        s_adv_step |=> op == $past(op))
        else $error("burst advance changed the operation");

    a_no_read_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (qual && next_op != fspc_pkg::FSPC_READ) |=> !drive_ok)
        else $error("drive permission without a read edge");

    // Reset is in the antecedent since the strap register reloads one edge late
    a_strap_linear: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && !burst_mode_i) |=> linear)
        else $error("strap low did not select linear order");

    a_strap_inter: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rst_i && burst_mode_i) |=> !linear)
        else $error("strap high did not select interleaved order");

    a_sleep_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_req_i |=> sleeping_o)
        else $error("sleep input not reported");

    a_sleep_desel: assert property (@(posedge clk_i) disable iff (rst_i)
        (qual && sleeping) |=> op == fspc_pkg::FSPC_IDLE)
        else $error("command accepted during sleep");

    a_burst_linear: assert property (@(posedge clk_i) disable iff (rst_i)
        s_adv_step and linear |-> next_addr[BW-1:0] == BW'(base_addr[BW-1:0] + burst_cnt + 1'b1))
        else $error("linear burst address wrong");

    a_burst_inter: assert property (@(posedge clk_i) disable iff (rst_i)
        s_adv_step and !linear
        |-> next_addr[BW-1:0] == (base_addr[BW-1:0] ^ BW'(burst_cnt + 1'b1)))
        else $error("interleaved burst address wrong");

endmodule // fspc_pin_ctrl

// ---- verif/fspc_ctrl_model.sv ----
// Purpose: Memory controller model on the far side of the pin control block
// Assumes: One clock; every pin except output enable changes just after a rising edge
// Notes:   Deselect picks a chip select from the two low address bits to reach all three
`timescale 1ns/1ps

module fspc_ctrl_model (
    // Clock
    input  wire logic        clk_i,
    // Command pins
    output logic [5:0]       addr_o,
    output logic             we_n_o,
    output logic             adv_o,
    output logic             cs_a_n_o,
    output logic             cs_b_o,
    output logic             cs_c_n_o,
    output logic             qual_n_o,
    output logic             oe_n_o,
    output logic             sleep_o,
    // Data pins
    output logic [31:0]      dq_o,
    output logic             dq_en_o
);
    // Quiet, deselected pins at time zero; sleep held low when unused
    initial begin
        {addr_o, we_n_o, adv_o, qual_n_o, oe_n_o, dq_en_o} = 11'h000;
        {cs_a_n_o, cs_b_o, cs_c_n_o} = 3'h5;
        sleep_o = 1'b0;
        dq_o = 32'h0;
    end

    // One command per edge; no access is sent while sleep is asked for
    task automatic cmd(input logic sel, input logic wn, input logic ad,
                       input logic [5:0] a, input logic den, input logic [31:0] d,
                       input logic q);
        @(posedge clk_i);
        // Deselect by address: 00/11 first select, 01 second, 10 third
        cs_a_n_o <= ~(sel & ~sleep_o) & ~(a[0] ^ a[1]);
        cs_b_o <= (sel & ~sleep_o) | ~(a[0] & ~a[1]);
        cs_c_n_o <= ~(sel & ~sleep_o) & a[1] & ~a[0];
        we_n_o <= wn;
        adv_o <= ad;
        addr_o <= a;
        qual_n_o <= q;
        dq_en_o <= den;
        dq_o <= d;
    endtask

    // Output enable is asynchronous, so it may move between edges
    task automatic set_oe(input logic v);
        oe_n_o <= v;
    endtask

    task automatic nap(input logic s);
        @(posedge clk_i);
        sleep_o <= s;
    endtask
endmodule // fspc_ctrl_model

// ---- verif/tb_fspc_pin_ctrl.sv ----
// Purpose: Self-checking bench for the SRAM pin control block
// Assumes: Address width lowered to 6; an integer array models the memory
// Notes:   Pin checks land at the falling edge, once the sampling edge settled; register checks follow the ack edge
`timescale 1ns/1ps

module tb_fspc_pin_ctrl;
    // Pins, bus and model state
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        mode = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [5:0]  addr;
    logic        we_n, adv, cs_a_n, cs_b, cs_c_n, qual_n, oe_n, sleep, dq_en, oe, slp, ack;
    logic [31:0] dq_c, dq_d, dq_w, rdat, rd, wdat = 32'h0, dq_last = 32'h0;
    logic [3:0]  wsel = 4'hF, wsel_next = 4'hF, bw_n = 4'h0, bw_next = 4'h0;
    int          n_fail = 0, comparisons = 0, i, m;
    int          mem [64];
    always #20 clk_i = ~clk_i;
    // A released bus shows the inverse of its last level
    assign dq_w = oe ? dq_d : (dq_en ? dq_c : ~dq_last);
    always @(posedge clk_i) dq_last <= dq_w;

    fspc_ctrl_model ctrl_inst (.clk_i(clk_i), .addr_o(addr), .we_n_o(we_n), .adv_o(adv),
        .cs_a_n_o(cs_a_n), .cs_b_o(cs_b), .cs_c_n_o(cs_c_n), .qual_n_o(qual_n),
        .oe_n_o(oe_n), .sleep_o(sleep), .dq_o(dq_c), .dq_en_o(dq_en));
    fspc_pin_ctrl #(.ADDR_W(6)) fspc_pin_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(addr), .write_en_n_i(we_n), .byte_lane_write_n_i(bw_n),
        .advance_or_load_i(adv), .chip_sel_a_n_i(cs_a_n), .chip_sel_b_i(cs_b),
        .chip_sel_c_n_i(cs_c_n), .clk_qualify_n_i(qual_n), .out_en_n_i(oe_n),
        .sleep_req_i(sleep), .burst_mode_i(mode), .dq_i(dq_w), .dq_o(dq_d), .dq_oe_o(oe),
        .sleeping_o(slp), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask

    // One command, then wait for the falling edge that shows the previous one
    task automatic go(input logic sel, input logic wn, input logic ad, input logic [5:0] a,
                      input logic den, input logic [31:0] d, input logic q);
        ctrl_inst.cmd(sel, wn, ad, a, den, d, q);
        bw_n <= bw_next;
        @(negedge clk_i);
    endtask

    // Classic single cycle; the bound on the wait ends a hang
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        wsel <= wsel_next;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        rd = rdat;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    initial begin
        i = $urandom(32'h0B48);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, fspc_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped read", rd, 32'h0);
        // Back-to-back writes, each one's data a cycle behind its command
        for (i = 0; i < 4; i++) begin
            mem[i] = $urandom;
            go(1'b1, 1'b0, 1'b0, i[5:0], i > 0, mem[i > 0 ? i - 1 : 0], 1'b0);
            if (i > 0) chk("oe in data cycle", oe, 32'h0);
        end
        for (i = 0; i < 5; i++) begin
            go(i < 4, 1'b1, 1'b0, i[5:0], i == 0, mem[3], 1'b0);
            if (i > 0) chk("read data", dq_d, mem[i - 1]);
            if (i > 0) chk("read drive", oe, 32'h1);
        end
        $display("write read test done");
        // Output enable held high, then lowered between edges
        ctrl_inst.set_oe(1'b1);
        go(1'b1, 1'b1, 1'b0, 6'h02, 1'b0, 32'h0, 1'b0);
        go(1'b0, 1'b1, 1'b0, 6'h02, 1'b0, 32'h0, 1'b0);
        chk("oe high floats", oe, 32'h0);
        chk("read data", dq_d, mem[2]);
        ctrl_inst.set_oe(1'b0);
        #1 chk("oe low drives", oe, 32'h1);
        go(1'b0, 1'b1, 1'b0, 6'h00, 1'b0, 32'h0, 1'b0);
        chk("deselected", oe, 32'h0);
        // Write stalled by the qualify input, then read back by forwarding
        m = $urandom;
        mem[7] = m;
        go(1'b1, 1'b0, 1'b0, 6'h07, 1'b0, 32'h0, 1'b0);
        go(1'b0, 1'b1, 1'b0, 6'h00, 1'b1, m, 1'b1);
        chk("oe data cycle", oe, 32'h0);
        go(1'b0, 1'b1, 1'b0, 6'h00, 1'b1, m, 1'b1);
        chk("oe stalled", oe, 32'h0);
        go(1'b1, 1'b1, 1'b0, 6'h07, 1'b1, m, 1'b0);
        for (i = 0; i < 3; i++) begin
            go(1'b0, 1'b1, 1'b0, 6'h00, 1'b0, 32'h0, i < 2);
            chk("stretched data", dq_d, mem[7]);
            chk("stretched drive", oe, 32'h1);
        end
        $display("qualify test done");
        // Byte lanes: full write, then one with lanes 1 and 3 masked off
        mem[5] = $urandom;
        m = $urandom;
        go(1'b1, 1'b0, 1'b0, 6'h05, 1'b0, 32'h0, 1'b0);
        bw_next = 4'hA;
        go(1'b1, 1'b0, 1'b0, 6'h05, 1'b1, mem[5], 1'b0);
        bw_next = 4'h0;
        mem[5] = (m & 32'h00FF00FF) | (mem[5] & 32'hFF00FF00);
        for (i = 0; i < 3; i++) begin
            go(i < 2, 1'b1, 1'b0, 6'h05, i == 0, m, 1'b0);
            if (i > 0) chk("lane write", dq_d, mem[5]);
        end
        $display("byte lane test done");
        // Burst from address 1 in both orders
        for (m = 0; m < 2; m++) begin
            @(posedge clk_i) mode <= m[0];
            go(1'b0, 1'b1, 1'b0, 6'h00, 1'b0, 32'h0, 1'b0);
            for (i = 0; i < 5; i++) begin
                go(i < 4, 1'b1, i > 0 && i < 4, 6'h01, 1'b0, 32'h0, 1'b0);
                if (i > 0) chk("burst", dq_d, mem[m ? (i - 1) ^ 1 : i & 3]);
            end
        end
        $display("burst test done");
        // Sleep from the register and from the pin; contents survive
        // A write with byte lane 0 disabled leaves the control bit alone
        wsel_next = 4'hE;
        wb(1'b1, fspc_pkg::REG_CTRL, 32'h1);
        wsel_next = 4'hF;
        wb(1'b0, fspc_pkg::REG_CTRL, 32'h0);
        chk("ctrl lane masked", rd, 32'h0);
        wb(1'b1, fspc_pkg::REG_CTRL, 32'h1);
        wb(1'b0, fspc_pkg::REG_STATUS, 32'h0);
        chk("status sleeping", rd[fspc_pkg::STAT_SLEEPING], 32'h1);
        wb(1'b1, fspc_pkg::REG_CTRL, 32'h0);
        ctrl_inst.nap(1'b1);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("sleep pin", slp, 32'h1);
        ctrl_inst.nap(1'b0);
        go(1'b1, 1'b1, 1'b0, 6'h02, 1'b0, 32'h0, 1'b0);
        go(1'b0, 1'b1, 1'b0, 6'h00, 1'b0, 32'h0, 1'b0);
        chk("kept data", dq_d, mem[2]);
        chk("awake", slp, 32'h0);
        $display("sleep test done");
        report_and_stop();
    end
endmodule // tb_fspc_pin_ctrl
